// >>> pkg/pbm_pkg.sv
//****************************************************************
// Overview of operation
//****************************************************************
`default_nettype none
package pbm_pkg;

	//****************************************************************
	// Register map
	//****************************************************************
	localparam logic [11:0] PBM_OFS_UPPER_FUNC = 12'h000;
	localparam logic [11:0] PBM_OFS_LOWER_FUNC = 12'h004;
	localparam logic [11:0] PBM_OFS_DIRECTION  = 12'h008;
	localparam logic [11:0] PBM_OFS_OUT_DATA   = 12'h00C;
	localparam logic [11:0] PBM_OFS_PIN_LEVEL  = 12'h010;

	localparam logic [15:0] PBM_RST_FUNC       = 16'h0000;
	localparam logic [15:0] PBM_RST_DIRECTION  = 16'h0000;
	localparam logic [15:0] PBM_RST_OUT_DATA   = 16'h0000;

	localparam int          PBM_UPPER_BASE     = 8;
	localparam int          PBM_CODE_W         = 2;

	//****************************************************************
	// Function codes and pin roles
	//****************************************************************
	localparam logic [1:0]  PBM_CODE_GPIO      = 2'h0;
	localparam logic [1:0]  PBM_CODE_ALT1      = 2'h1;
	localparam logic [1:0]  PBM_CODE_ALT2      = 2'h2;
	localparam logic [1:0]  PBM_CODE_PATTERN   = 2'h3;

	typedef enum logic [2:0]
	{
		PBM_KIND_GPIO = 3'b000,
		PBM_KIND_IRQ  = 3'b001,
		PBM_KIND_SCK  = 3'b010,
		PBM_KIND_TXD  = 3'b011,
		PBM_KIND_RXD  = 3'b100,
		PBM_KIND_TP   = 3'b101
	} pbm_kind_t;

	// Pin index is 0..7 for port pins 8..15
	function automatic pbm_kind_t pbm_pin_kind(input logic [2:0] pin, input logic [1:0] code);
		pbm_kind_t k;
		k = PBM_KIND_GPIO;
		case (code)
			PBM_CODE_GPIO:
				k = PBM_KIND_GPIO;
			PBM_CODE_ALT1:
				k = pin[2] ? PBM_KIND_IRQ : PBM_KIND_GPIO;
			PBM_CODE_ALT2:
			begin
				case (pin)
					3'h7, 3'h6: k = PBM_KIND_GPIO;
					3'h5, 3'h4: k = PBM_KIND_SCK;
					3'h3, 3'h1: k = PBM_KIND_TXD;
					default:    k = PBM_KIND_RXD;
				endcase
			end
			default:
				k = PBM_KIND_TP;
		endcase
		return k;
	endfunction

	function automatic logic [15:0] pbm_merge16(input logic [15:0] old, input logic [31:0] wdata,
		input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0])
			r[7:0] = wdata[7:0];
		if (strb[1])
			r[15:8] = wdata[15:8];
		return r;
	endfunction

endpackage
`default_nettype wire

// >>> hw/pbm_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pbm_sync
	import pbm_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] RST_VAL = '1
)
(
	input  wire logic             i_sys_clk,
	input  wire logic             i_sys_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	//****************************************************************
	// Two-stage synchroniser, first stage read only by second
	//****************************************************************
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end
		else
		begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule
`default_nettype wire

// >>> hw/pbm_upper_mux.sv
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module pbm_upper_mux
	import pbm_pkg::*;
#(
	parameter int PINS = 8
)
(
	input  wire logic            i_sys_clk,
	input  wire logic            i_sys_rst,
	input  wire logic            i_manual_rst,
	// APB slave
	input  wire logic            i_psel,
	input  wire logic            i_penable,
	input  wire logic            i_pwrite,
	input  wire logic [11:0]     i_paddr,
	input  wire logic [31:0]     i_pwdata,
	input  wire logic [3:0]      i_pstrb,
	output logic      [31:0]     o_prdata,
	output logic                 o_pready,
	output logic                 o_pslverr,
	// Pads 15..8
	input  wire logic [PINS-1:0] i_pin_in,
	output logic      [PINS-1:0] o_pin_out,
	output logic      [PINS-1:0] o_pin_oe_n,
	// Peripheral side
	output logic      [3:0]      o_ext_interrupt_line,
	output logic      [1:0]      o_serial_clock_in,
	input  wire logic [1:0]      i_serial_clock_out,
	input  wire logic [1:0]      i_serial_tx,
	output logic      [1:0]      o_serial_rx,
	input  wire logic [PINS-1:0] i_timing_pattern,
	// Lower half settings for the pin 7..0 mux
	output logic      [15:0]     o_lower_func_sel,
	output logic      [7:0]      o_lower_dir,
	output logic      [7:0]      o_lower_out_data
);

	//****************************************************************
	// Registers
	//****************************************************************
	logic [15:0]     upper_func_q;
	logic [15:0]     lower_func_q;
	logic [15:0]     dir_q;
	logic [15:0]     out_data_q;
	logic [31:0]     prdata_q;
	logic            pready_q;
	logic            pslverr_q;
	logic [PINS-1:0] pin_out_q;
	logic [PINS-1:0] pin_oe_n_q;
	logic [3:0]      irq_q;
	logic [1:0]      sck_in_q;
	logic [1:0]      rx_q;
	logic [PINS-1:0] pin_sync;

	pbm_sync #(
		.WIDTH   (PINS),
		.RST_VAL ({PINS{1'b1}})
	) u_pin_sync (
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   (i_pin_in),
		.o_sync    (pin_sync)
	);

	// Upper direction byte split out once, shared by all pin slices
	logic [7:0]      upper_dir;

	pbm_dir_view u_dir_view (
		.i_dir       (dir_q),
		.o_upper_dir (upper_dir)
	);

	//****************************************************************
	// APB decode
	//****************************************************************
	// One wait state so that read data and pready come from flops
	wire logic        access    = i_psel & i_penable;
	wire logic        start     = access & ~pready_q;
	wire logic        commit_wr = access & pready_q & i_pwrite;
	wire logic        hit_upper = (i_paddr == PBM_OFS_UPPER_FUNC);
	wire logic        hit_lower = (i_paddr == PBM_OFS_LOWER_FUNC);
	wire logic        hit_dir   = (i_paddr == PBM_OFS_DIRECTION);
	wire logic        hit_data  = (i_paddr == PBM_OFS_OUT_DATA);
	wire logic        hit_pin   = (i_paddr == PBM_OFS_PIN_LEVEL);
	wire logic        mapped    = hit_upper | hit_lower | hit_dir | hit_data | hit_pin;
	wire logic [15:0] pin_word  = {pin_sync, 8'h00};
	wire logic [15:0] rd_word   = hit_upper ? upper_func_q :
	                              hit_lower ? lower_func_q :
	                              hit_dir   ? dir_q :
	                              hit_data  ? out_data_q :
	                              hit_pin   ? pin_word : 16'h0000;

	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end
		else
		begin
			pready_q  <= start;
			pslverr_q <= start & ~mapped;
			prdata_q  <= (start & ~i_pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
		end
	end

	//****************************************************************
	// Function select and direction, power-on reset only
	//****************************************************************
	// Manual reset deliberately not wired here: settings survive it
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			upper_func_q <= PBM_RST_FUNC;
			lower_func_q <= PBM_RST_FUNC;
			dir_q        <= PBM_RST_DIRECTION;
		end
		else
		begin
			if (commit_wr & hit_upper)
				upper_func_q <= pbm_merge16(upper_func_q, i_pwdata, i_pstrb);
			if (commit_wr & hit_lower)
				lower_func_q <= pbm_merge16(lower_func_q, i_pwdata, i_pstrb);
			if (commit_wr & hit_dir)
				dir_q        <= pbm_merge16(dir_q, i_pwdata, i_pstrb);
		end
	end

	// Output latch is ordinary port state, so manual reset clears it
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			out_data_q <= PBM_RST_OUT_DATA;
		else if (i_manual_rst)
			out_data_q <= PBM_RST_OUT_DATA;
		else if (commit_wr & hit_data)
			out_data_q <= pbm_merge16(out_data_q, i_pwdata, i_pstrb);
	end

	//****************************************************************
	// Per-pin routing
	//****************************************************************
	pbm_kind_t       kind [PINS];
	logic [PINS-1:0] drv_val;
	logic [PINS-1:0] drv_oe_n;

	for (genvar j = 0; j < PINS; j++)
	begin : g_pin
		localparam logic [2:0] PIN = 3'(j);
		wire logic dir_bit = upper_dir[j];
		assign kind[j] = pbm_pin_kind(PIN, upper_func_q[PBM_CODE_W*j +: PBM_CODE_W]);
		assign drv_val[j] = (kind[j] == PBM_KIND_SCK) ? i_serial_clock_out[PIN[0]] :
		                    (kind[j] == PBM_KIND_TXD) ? i_serial_tx[PIN[1]] :
		                    (kind[j] == PBM_KIND_TP)  ? i_timing_pattern[j] :
		                    out_data_q[PBM_UPPER_BASE + j];
		// Active low enable; receive-only roles never drive the pad
		assign drv_oe_n[j] = ((kind[j] == PBM_KIND_GPIO) || (kind[j] == PBM_KIND_SCK)) ? ~dir_bit :
		                     ((kind[j] == PBM_KIND_TXD) || (kind[j] == PBM_KIND_TP)) ? 1'b0 : 1'b1;
	end

	// Unselected peripheral inputs idle high so no false edges reach them
	wire logic [3:0] irq_d;
	wire logic [1:0] sck_d;
	wire logic [1:0] rx_d;

	for (genvar k = 0; k < 4; k++)
	begin : g_irq
		assign irq_d[k] = (kind[k+4] == PBM_KIND_IRQ) ? pin_sync[k+4] : 1'b1;
	end

	for (genvar c = 0; c < 2; c++)
	begin : g_ser
		assign sck_d[c] = (kind[c+4] == PBM_KIND_SCK) ? pin_sync[c+4] : 1'b1;
		assign rx_d[c]  = (kind[2*c] == PBM_KIND_RXD) ? pin_sync[2*c] : 1'b1;
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pin_out_q  <= '0;
			pin_oe_n_q <= '1;
			irq_q      <= 4'hF;
			sck_in_q   <= 2'h3;
			rx_q       <= 2'h3;
		end
		else
		begin
			pin_out_q  <= drv_val;
			pin_oe_n_q <= drv_oe_n;
			irq_q      <= irq_d;
			sck_in_q   <= sck_d;
			rx_q       <= rx_d;
		end
	end

	//****************************************************************
	// Outputs
	//****************************************************************
	assign o_prdata             = prdata_q;
	assign o_pready             = pready_q;
	assign o_pslverr            = pslverr_q;
	assign o_pin_out            = pin_out_q;
	assign o_pin_oe_n           = pin_oe_n_q;
	assign o_ext_interrupt_line = irq_q;
	assign o_serial_clock_in    = sck_in_q;
	assign o_serial_rx          = rx_q;
	assign o_lower_func_sel     = lower_func_q;
	assign o_lower_dir          = dir_q[7:0];
	assign o_lower_out_data     = out_data_q[7:0];

endmodule
`default_nettype wire

// >>> hw/pbm_unused_placeholder_none.sv
`timescale 1ns/10ps
`default_nettype none
module pbm_dir_view
	import pbm_pkg::*;
(
	input  wire logic [15:0] i_dir,
	output logic      [7:0]  o_upper_dir
);

	assign o_upper_dir = i_dir[15:8];

endmodule
`default_nettype wire

// >>> bench/pbm_pads.sv
`timescale 1ns/10ps
`default_nettype none
//****************************************************************
// Pad model
//****************************************************************
module pbm_pads
(
	input  wire logic [7:0] i_out,
	input  wire logic [7:0] i_oe_n,
	input  wire logic [7:0] i_ext,
	output logic      [7:0] o_level
);
	// Driven pad wins, a released pad shows the far side
	assign o_level = (i_out & ~i_oe_n) | (i_ext & i_oe_n);
endmodule
`default_nettype wire

// >>> bench/pbm_upper_mux_chk.sv
`timescale 1ns/10ps
`default_nettype none
//****************************************************************
// Checker
//****************************************************************
module pbm_upper_mux_chk
	import pbm_pkg::*;
#(
	parameter int PINS = 8
)
(
	input  wire logic            i_sys_clk,
	input  wire logic            i_sys_rst,
	input  wire logic            i_psel,
	input  wire logic            i_penable,
	input  wire logic            i_pwrite,
	input  wire logic [11:0]     i_paddr,
	input  wire logic [31:0]     i_pwdata,
	input  wire logic [3:0]      i_pstrb,
	input  wire logic            o_pready,
	input  wire logic            o_pslverr,
	input  wire logic [PINS-1:0] o_pin_out,
	input  wire logic [PINS-1:0] o_pin_oe_n,
	input  wire logic [1:0]      i_serial_clock_out,
	input  wire logic [1:0]      i_serial_tx,
	input  wire logic [PINS-1:0] i_timing_pattern
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	// Bus-side copy of the select, so pins can be judged
	logic [15:0] sel_q;
	wire         hit = i_psel & i_penable & o_pready & i_pwrite & (i_paddr == PBM_OFS_UPPER_FUNC);
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
		if (i_sys_rst)
			sel_q <= PBM_RST_FUNC;
		else if (hit)
			sel_q <= {i_pstrb[1] ? i_pwdata[15:8] : sel_q[15:8], i_pstrb[0] ? i_pwdata[7:0] : sel_q[7:0]};
	sequence s_answer;
		o_pready ##1 !o_pready;
	endsequence
	a_ready_pulse: assert property (o_pready |-> s_answer) else $error("pready held");
	a_err_ready: assert property (o_pslverr |-> o_pready) else $error("lone pslverr");
	a_pattern_pin: assert property ($past(sel_q[15:14]) == 2'h3
		|-> !o_pin_oe_n[7] && o_pin_out[7] == $past(i_timing_pattern[7])) else $error("pattern 15");
	a_irq_float: assert property ($past(sel_q[13:12]) == 2'h1 |-> o_pin_oe_n[6]) else $error("irq 6 driven");
	a_tx_ch1: assert property ($past(sel_q[7:6]) == 2'h2
		|-> !o_pin_oe_n[3] && o_pin_out[3] == $past(i_serial_tx[1])) else $error("tx 1");
	a_tx_ch0: assert property ($past(sel_q[3:2]) == 2'h2
		|-> !o_pin_oe_n[1] && o_pin_out[1] == $past(i_serial_tx[0])) else $error("tx 0");
	// Clock pins are checked for their value only while they drive
	a_serial_clock_ch1_drive: assert property ($past(sel_q[11:10]) == 2'h2 && !o_pin_oe_n[5]
		|-> o_pin_out[5] == $past(i_serial_clock_out[1])) else $error("sck 1");
	a_serial_clock_ch0_drive: assert property ($past(sel_q[9:8]) == 2'h2 && !o_pin_oe_n[4]
		|-> o_pin_out[4] == $past(i_serial_clock_out[0])) else $error("sck 0");
	a_rx_float: assert property ($past(sel_q[5:4]) == 2'h2 |-> o_pin_oe_n[2]) else $error("rx 1 driven");
	a_rx0_float: assert property ($past(sel_q[1:0]) == 2'h2 |-> o_pin_oe_n[0]) else $error("rx 0 driven");
endmodule
bind pbm_upper_mux pbm_upper_mux_chk #(.PINS(PINS)) chk_u (.i_sys_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite,
	.i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_pslverr, .o_pin_out, .o_pin_oe_n, .i_serial_clock_out,
	.i_serial_tx, .i_timing_pattern);
`default_nettype wire

// >>> bench/test_pbm_upper_mux.sv
`timescale 1ns/10ps
`default_nettype none
module test_pbm_upper_mux
	import pbm_pkg::*;
;
	logic        clk, rst, mrst, psel, penable, pwrite, pready, pslverr, erv;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv, r;
	logic [3:0]  pstrb, irq;
	logic [7:0]  pin_in, pin_out, oe_n, ext, tp, lo_dir, lo_od;
	logic [1:0]  sck_in, sck_o, tx, rx;
	logic [15:0] lo_fs, m[4];
	int          seed, mismatches, n_compared, i;
	pbm_upper_mux #(.PINS(8)) dut_u (.i_sys_clk(clk), .i_sys_rst(rst), .i_manual_rst(mrst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pin_in(pin_in), .o_pin_out(pin_out),
		.o_pin_oe_n(oe_n), .o_ext_interrupt_line(irq), .o_serial_clock_in(sck_in), .i_serial_clock_out(sck_o),
		.i_serial_tx(tx), .o_serial_rx(rx), .i_timing_pattern(tp), .o_lower_func_sel(lo_fs),
		.o_lower_dir(lo_dir), .o_lower_out_data(lo_od));
	pbm_pads pads_u (.i_out(pin_out), .i_oe_n(oe_n), .i_ext(ext), .o_level(pin_in));
	//****************************************************************
	// Bus and compare tasks
	//****************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		chk(n < 50, 1);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, a, d, s);
		if (s[0] && a < PBM_OFS_PIN_LEVEL)
			m[a[3:2]][7:0] = d[7:0];
		if (s[1] && a < PBM_OFS_PIN_LEVEL)
			m[a[3:2]][15:8] = d[15:8];
		chk(erv, 0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, 4'h0);
		chk(rdv, e);
	endtask
	task automatic pins();
		logic [7:0] eo, en, lv;
		logic [3:0] ei;
		logic [1:0] es, er, c;
		int         j, k;
		ei = '1;
		es = '1;
		er = '1;
		for (j = 0; j < 8; j++)
		begin
			c = m[0][2*j +: 2];
			// 0 gpio, 1 irq, 2 sck, 3 tx, 4 rx, 5 pattern
			k = (c == 2'h3) ? 5 : (c == 2'h1 && j > 3) ? 1 : (c != 2'h2 || j > 5) ? 0 : (j > 3) ? 2 : 4 - j % 2;
			en[j] = (k == 3 || k == 5) ? 1'b0 : (k == 1 || k == 4) ? 1'b1 : ~m[2][8+j];
			eo[j] = (k == 5) ? tp[j] : (k == 3) ? tx[j/2] : (k == 2) ? sck_o[j-4] : m[3][8+j];
			lv[j] = en[j] ? ext[j] : eo[j];
			if (k == 1)
				ei[j-4] = lv[j];
			if (k == 2)
				es[j-4] = lv[j];
			if (k == 4)
				er[j/2] = lv[j];
		end
		chk(oe_n, en);
		chk(pin_out & ~en, eo & ~en);
		chk({irq, sck_in, rx}, {ei, es, er});
		chk({lo_fs, lo_od, lo_dir}, {m[1], m[3][7:0], m[2][7:0]});
		rd(PBM_OFS_PIN_LEVEL, {16'h0000, lv, 8'h00});
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	//****************************************************************
	// Clock, watchdog, tests
	//****************************************************************
	initial
	begin
		clk = 1'b0;
		forever
			#5 clk = ~clk;
	end
	initial
	begin
		#100000;
		mismatches++;
		results();
	end
	initial
	begin
		seed = 4;
		mismatches = 0;
		n_compared = 0;
		{rst, mrst, psel, penable, pwrite} = 5'b10000;
		{paddr, pwdata, pstrb, ext, tp, tx, sck_o} = '0;
		m = '{default: 16'h0000};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 4; i++)
			rd(12'(4 * i), 32'h0000_0000);
		apb(1'b1, 12'h014, 32'hFFFF_FFFF, 4'hF);
		chk(erv, 1);
		pins();
		$display("test reset done");
		// Reserved codes are written too, to prove they stay plain I/O
		for (i = 0; i < 40; i++)
		begin
			r = $random(seed);
			{ext, tp, tx, sck_o} <= r[19:0];
			wr(PBM_OFS_UPPER_FUNC, (i < 4) ? {16{i[1:0]}} : $random(seed), 4'h3);
			wr(PBM_OFS_LOWER_FUNC, $random(seed), 4'h3);
			r = $random(seed);
			wr(PBM_OFS_DIRECTION, r, r[19:16]);
			wr(PBM_OFS_OUT_DATA, $random(seed), 4'h3);
			repeat (6) @(posedge clk);
			pins();
			rd(PBM_OFS_UPPER_FUNC, {16'h0000, m[0]});
		end
		$display("test mux done");
		mrst <= 1'b1;
		@(posedge clk);
		mrst <= 1'b0;
		m[3] = 16'h0000;
		repeat (6) @(posedge clk);
		pins();
		for (i = 0; i < 4; i++)
			rd(12'(4 * i), {16'h0000, m[i]});
		$display("test manual reset done");
		// Power-on reset in mid-run must clear what the last test left behind
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		m = '{default: 16'h0000};
		repeat (6) @(posedge clk);
		pins();
		for (i = 0; i < 4; i++)
			rd(12'(4 * i), 32'h0000_0000);
		$display("test power-on reset done");
		results();
	end
endmodule
`default_nettype wire
